// file: core/gauge_pkg.sv
// Shared constants for the fuel gauge register link
package gauge_pkg;
  localparam logic [6:0] SLAVE_ADDR = 7'h36;
  localparam logic [7:0] VOLT_ADDR = 8'h02;
  localparam logic [7:0] CHG_ADDR = 8'h04;
  localparam logic [7:0] SPECIAL_ADDR = 8'h06;
  localparam logic [7:0] REV_ADDR = 8'h08;
  localparam logic [7:0] COMP_ADDR = 8'h0c;
  localparam logic [7:0] RESET_ADDR = 8'hfe;
  localparam logic [15:0] COMP_RESET = 16'h9700;
  localparam logic [15:0] QUICK_START_CODE = 16'h4000;
  localparam logic [15:0] FULL_RESET_CODE = 16'h5400;
  localparam logic [7:0] RESERVED_BYTE = 8'hff;
  localparam int VOLT_W = 12;
  localparam int SYS_CLK_HZ = 40_000_000;
  localparam int OSC_HZ = 32768;
  localparam int OSC_TICK_CYC = SYS_CLK_HZ / OSC_HZ;
  localparam int OSC_HALF_CYC = SYS_CLK_HZ / (2 * OSC_HZ);
  localparam int FIRST_CONV_MS = 125;
  localparam int LATER_CONV_MS = 500;
  localparam int FIRST_CONV_TICKS = FIRST_CONV_MS * OSC_HZ / 1000;
  localparam int LATER_CONV_TICKS = LATER_CONV_MS * OSC_HZ / 1000;
  localparam int VOLT_STEP_UV_1S = 1250;
  localparam int VOLT_STEP_UV_2S = 2500;
  localparam int SCL_HZ = 100_000;
  localparam int SCL_QUARTER_CYC = SYS_CLK_HZ / (4 * SCL_HZ);
  localparam logic [7:0] HCMD_OFS = 8'h00;
  localparam logic [7:0] HWDATA_OFS = 8'h04;
  localparam logic [7:0] HRDATA_OFS = 8'h08;
  localparam logic [7:0] HSTATUS_OFS = 8'h0c;
  localparam logic [7:0] HPINS_OFS = 8'h10;
  localparam int CMD_READ_BIT = 8;
  localparam int PINS_SELECT_BIT = 0;
  localparam int PINS_TRIGGER_BIT = 1;
  localparam int PINS_CLKGEN_BIT = 2;
endpackage

// file: core/gauge_link_if.sv
// Two-wire link plus clock-select and clock/trigger pins
`timescale 1ns/1ps
interface gauge_link_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;
  logic clock_source_select;
  logic clock_or_trigger_input;
  // Open drain: any enabled low driver pulls the line
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
  modport host_end(output scl, host_sda_o, host_sda_oe, clock_source_select, clock_or_trigger_input,
    input sda);
  modport device_end(input scl, sda, clock_source_select, clock_or_trigger_input,
    output dev_sda_o, dev_sda_oe);
endinterface

// file: core/conversion_timebase.sv
// Conversion period timer and voltage averager
`timescale 1ns/1ps
module conversion_timebase import gauge_pkg::*; #(
  parameter int FIRST_TICKS = FIRST_CONV_TICKS,
  parameter int LATER_TICKS = LATER_CONV_TICKS,
  parameter int TICK_CYC = OSC_TICK_CYC,
  parameter int SAMPLE_W = VOLT_W
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic ext_mode_in,
  input wire logic ext_tick_in,
  input wire logic restart_in,
  input wire logic [SAMPLE_W-1:0] sample_in,
  output logic done_out,
  output logic [SAMPLE_W-1:0] average_out
);
  // Periods are powers of two so the average is a shift
  localparam int FW = $clog2(FIRST_TICKS);
  localparam int LW = $clog2(LATER_TICKS);
  localparam int ACC_W = SAMPLE_W + LW;
  localparam int DW = $clog2(TICK_CYC + 1);
  logic [DW-1:0] div_q;
  logic [LW:0] cnt_q;
  logic first_q;
  logic [ACC_W-1:0] acc_q;
  logic int_tick;
  logic tick;
  logic last;
  logic [LW:0] period;
  logic [ACC_W-1:0] sum;

  assign int_tick = div_q == DW'(TICK_CYC - 1);
  assign tick = ext_mode_in ? ext_tick_in : int_tick;
  assign period = first_q ? (LW+1)'(FIRST_TICKS) : (LW+1)'(LATER_TICKS);
  assign last = tick && cnt_q == period - 1'b1;
  assign sum = acc_q + ACC_W'(sample_in);

  always_ff @(posedge sys_clk_in) begin
    if (srst_in || restart_in) begin
      div_q <= '0;
    end else if (ce_in) begin
      div_q <= int_tick ? '0 : div_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in || restart_in) begin
      cnt_q <= '0;
      first_q <= 1'b1;
      acc_q <= '0;
    end else if (ce_in && tick) begin
      cnt_q <= last ? '0 : cnt_q + 1'b1;
      acc_q <= last ? '0 : sum;
      if (last) begin
        first_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      done_out <= 1'b0;
      average_out <= '0;
    end else if (ce_in) begin
      done_out <= last;
      if (last) begin
        average_out <= first_q ? SAMPLE_W'(sum >> FW) : SAMPLE_W'(sum >> LW);
      end
    end
  end
endmodule

// file: core/gauge_device.sv
// Gauge device end: two-wire register slave and measurement registers
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
// Contract
// - six 16-bit registers, whole words only
// - partial word write is discarded
// - master treats reserved reads as undefined
// - voltage at 02h, read-only, 12-bit
// - 1.25mV or 2.50mV per step
// - average 125ms first, then 500ms
// - charge at 04h, read-only, 16-bit
// - high byte percent, low byte 1/256
// - charge first updates 125ms after reset
// - charge result saturates to register range
// - 06h write-only, 4000h starts quick-start
// - revision at 08h, read-only
// - compensation at 0Ch, read/write, 9700h
// - FEh write-only, 5400h fully resets
// - select high: external 32kHz timebase
// - select low: rising trigger quick-starts
// - high byte first at even address
// - pointer increments after each byte
// - reset at last bit, no acknowledge
// - quick-start restarts as at power-up
module gauge_device import gauge_pkg::*; #(
  parameter logic [15:0] VERSION_CODE = 16'h0011, // Arbitrary value
  parameter bit DUAL_CELL = 1'b0,
  parameter int FIRST_TICKS = FIRST_CONV_TICKS,
  parameter int LATER_TICKS = LATER_CONV_TICKS,
  parameter int TICK_CYC = OSC_TICK_CYC,
  parameter int SOC_W = 20
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  gauge_link_if.device_end link,
  input wire logic [VOLT_W-1:0] voltage_sample_in,
  input wire logic signed [SOC_W-1:0] soc_estimate_in,
  output logic conversion_done_out,
  output logic quick_start_out,
  output logic full_reset_out,
  output logic [15:0] compensation_out,
  output logic [23:0] cell_voltage_uv_out
);
  localparam int STEP_UV = DUAL_CELL ? VOLT_STEP_UV_2S : VOLT_STEP_UV_1S;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_PTR, ST_WRITE, ST_ACK, ST_READ, ST_MACK
  } link_state_t;

  link_state_t state_q;
  link_state_t next_q;
  logic rst;
  logic scl_q;
  logic sda_q;
  logic oe_q;
  logic acked_q;
  logic hold_ok_q;
  logic snap_ok_q;
  logic [3:0] bit_q;
  logic [7:0] shift_q;
  logic [7:0] ptr_q;
  logic [7:0] hold_q;
  logic [15:0] snap_q;
  logic [15:0] volt_q;
  logic [15:0] soc_q;
  logic [15:0] comp_q;
  logic [23:0] uv_q;
  logic sel_m_q;
  logic sel_q;
  logic eo_m_q;
  logic eo_q;
  logic eo_prev_q;
  logic qs_q;
  logic por_q;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic byte_in;
  logic commit;
  logic por_cmd;
  logic load_rd;
  logic eo_rise;
  logic [7:0] rx_byte;
  logic [7:0] base;
  logic [7:0] tx_byte;
  logic [15:0] wdata;
  logic [15:0] word;
  logic [15:0] sat;
  logic [VOLT_W-1:0] average;
  logic conv_done;

  // Command reset clears everything except its own pulse and the pin input flops
  assign rst = srst_in || por_q;

  // Pin inputs from outside logic, two flops first
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      sel_m_q <= 1'b0;
      sel_q <= 1'b0;
      eo_m_q <= 1'b0;
      eo_q <= 1'b0;
      eo_prev_q <= 1'b0;
    end else if (ce_in) begin
      sel_m_q <= link.clock_source_select;
      sel_q <= sel_m_q;
      eo_m_q <= link.clock_or_trigger_input;
      eo_q <= eo_m_q;
      eo_prev_q <= eo_q;
    end
  end

  assign eo_rise = eo_q && !eo_prev_q;
  assign scl_rise = link.scl && !scl_q;
  assign scl_fall = !link.scl && scl_q;
  assign bus_start = link.scl && scl_q && sda_q && !link.sda;
  assign bus_stop = link.scl && scl_q && !sda_q && link.sda;
  assign rx_byte = {shift_q[6:0], link.sda};
  assign base = {ptr_q[7:1], 1'b0};
  assign wdata = {hold_q, rx_byte};
  assign byte_in = scl_rise && bit_q == 4'd7 &&
    (state_q == ST_ADDR || state_q == ST_PTR || state_q == ST_WRITE);
  // Odd byte completes a word only after its even partner
  assign commit = byte_in && state_q == ST_WRITE && ptr_q[0] && hold_ok_q;
  assign por_cmd = commit && base == RESET_ADDR && wdata == FULL_RESET_CODE;
  assign load_rd = scl_fall && ((state_q == ST_ACK && next_q == ST_READ) ||
    (state_q == ST_MACK && acked_q));

  always_comb begin
    case (base)
      VOLT_ADDR: word = volt_q;
      CHG_ADDR: word = soc_q;
      REV_ADDR: word = VERSION_CODE;
      COMP_ADDR: word = comp_q;
      default: word = {RESERVED_BYTE, RESERVED_BYTE};
    endcase
  end

  // Odd byte comes from the word frozen with its even byte
  assign tx_byte = !ptr_q[0] ? word[15:8] : (snap_ok_q ? snap_q[7:0] : word[7:0]);

  always_ff @(posedge sys_clk_in) begin
    if (rst) begin
      state_q <= ST_IDLE;
      next_q <= ST_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      oe_q <= 1'b0;
      acked_q <= 1'b0;
      hold_ok_q <= 1'b0;
      snap_ok_q <= 1'b0;
      bit_q <= '0;
      shift_q <= '0;
      ptr_q <= '0;
      hold_q <= '0;
      snap_q <= '0;
    end else if (ce_in) begin
      scl_q <= link.scl;
      sda_q <= link.sda;
      if (bus_start) begin
        state_q <= ST_ADDR;
        bit_q <= '0;
        oe_q <= 1'b0;
        hold_ok_q <= 1'b0;
        snap_ok_q <= 1'b0;
      end else if (bus_stop) begin
        state_q <= ST_IDLE;
        oe_q <= 1'b0;
        hold_ok_q <= 1'b0;
      end else begin
        case (state_q)
          ST_ADDR, ST_PTR, ST_WRITE: begin
            if (scl_rise) begin
              shift_q <= rx_byte;
              bit_q <= bit_q + 1'b1;
            end
            if (byte_in) begin
              acked_q <= 1'b1;
              next_q <= ST_WRITE;
              if (state_q == ST_ADDR) begin
                acked_q <= rx_byte[7:1] == SLAVE_ADDR;
                next_q <= rx_byte[0] ? ST_READ : ST_PTR;
              end else if (state_q == ST_PTR) begin
                ptr_q <= rx_byte;
              end else begin
                ptr_q <= ptr_q + 1'b1;
                hold_q <= rx_byte;
                hold_ok_q <= !ptr_q[0];
                if (por_cmd) begin
                  acked_q <= 1'b0;
                end
              end
            end
            if (scl_fall && bit_q == 4'd8) begin
              state_q <= acked_q ? ST_ACK : ST_IDLE;
              oe_q <= acked_q;
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              bit_q <= '0;
              state_q <= next_q;
              oe_q <= 1'b0;
            end
          end
          ST_READ: begin
            if (scl_fall) begin
              bit_q <= bit_q + 1'b1;
              shift_q <= {shift_q[6:0], 1'b1};
              if (bit_q == 4'd7) begin
                state_q <= ST_MACK;
                oe_q <= 1'b0;
              end else begin
                oe_q <= !shift_q[6];
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              acked_q <= !link.sda;
            end
            if (scl_fall) begin
              bit_q <= '0;
              state_q <= acked_q ? ST_READ : ST_IDLE;
            end
          end
          default: state_q <= ST_IDLE;
        endcase
        if (load_rd) begin
          ptr_q <= ptr_q + 1'b1;
          shift_q <= tx_byte;
          oe_q <= !tx_byte[7];
          if (!ptr_q[0]) begin
            snap_q <= word;
            snap_ok_q <= 1'b1;
          end
        end
      end
    end
  end

  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = oe_q;

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      por_q <= 1'b0;
    end else if (ce_in) begin
      por_q <= por_cmd;
    end
  end

  always_comb begin
    if (soc_estimate_in < 0) begin
      sat = 16'h0000;
    end else if (soc_estimate_in > SOC_W'(16'hffff)) begin
      sat = 16'hffff;
    end else begin
      sat = soc_estimate_in[15:0];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst) begin
      comp_q <= COMP_RESET;
      volt_q <= '0;
      soc_q <= '0;
      uv_q <= '0;
      qs_q <= 1'b0;
    end else if (ce_in) begin
      qs_q <= (commit && base == SPECIAL_ADDR && wdata == QUICK_START_CODE) ||
        (!sel_q && eo_rise);
      if (commit && base == COMP_ADDR) begin
        comp_q <= wdata;
      end
      if (conv_done) begin
        volt_q <= 16'(average);
        soc_q <= sat;
        uv_q <= 24'(average) * 24'(STEP_UV);
      end
    end
  end

  // Quick-start restarts the first short period
  conversion_timebase #(
    .FIRST_TICKS(FIRST_TICKS),
    .LATER_TICKS(LATER_TICKS),
    .TICK_CYC(TICK_CYC),
    .SAMPLE_W(VOLT_W)
  ) timebase (
    .sys_clk_in(sys_clk_in),
    .srst_in(rst),
    .ce_in(ce_in),
    .ext_mode_in(sel_q),
    .ext_tick_in(eo_rise),
    .restart_in(qs_q),
    .sample_in(voltage_sample_in),
    .done_out(conv_done),
    .average_out(average)
  );

  assign conversion_done_out = conv_done;
  assign quick_start_out = qs_q;
  assign full_reset_out = por_q;
  assign compensation_out = comp_q;
  assign cell_voltage_uv_out = uv_q;
endmodule

// file: core/gauge_host.sv
// Host end: Wishbone-controlled two-wire master for the gauge
`timescale 1ns/1ps
module gauge_host import gauge_pkg::*; #(
  parameter int QUARTER_CYC = SCL_QUARTER_CYC,
  parameter int HALF_CYC = OSC_HALF_CYC
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [3:0] wb_sel_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  gauge_link_if.host_end link
);
  localparam int QW = $clog2(QUARTER_CYC + 1);
  localparam int HW = $clog2(HALF_CYC + 1);
  typedef enum logic [1:0] {TK_START, TK_WRITE, TK_READ, TK_STOP} token_t;

  logic ack_q;
  logic busy_q;
  logic nack_q;
  logic done_q;
  logic rd_q;
  logic [7:0] ptr_q;
  logic [15:0] wdata_q;
  logic [15:0] rdata_q;
  logic [2:0] pins_q;
  logic [2:0] step_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [QW-1:0] div_q;
  logic [7:0] shift_q;
  logic scl_q;
  logic oe_q;
  logic [HW-1:0] gen_div_q;
  logic gen_clk_q;
  logic trig_out_q;
  logic wr;
  logic go;
  logic qt;
  logic bad_value;
  token_t tok;
  logic [2:0] stop_step;

  function automatic token_t token_of(input logic [2:0] s, input logic r);
    if (s == 3'd0 || (r && s == 3'd3)) begin
      return TK_START;
    end else if (s == (r ? 3'd7 : 3'd5)) begin
      return TK_STOP;
    end else if (r && s >= 3'd5) begin
      return TK_READ;
    end
    return TK_WRITE;
  endfunction

  // Two data bytes always, high byte first
  function automatic logic [7:0] byte_of(input logic [2:0] s, input logic r, input logic [7:0] p,
    input logic [15:0] d);
    case (s)
      3'd1: return {SLAVE_ADDR, 1'b0};
      3'd2: return p;
      3'd3: return d[15:8];
      3'd4: return r ? {SLAVE_ADDR, 1'b1} : d[7:0];
      default: return 8'hff;
    endcase
  endfunction

  assign tok = token_of(step_q, rd_q);
  assign stop_step = rd_q ? 3'd7 : 3'd5;
  assign wr = wb_cyc_in && wb_stb_in && wb_we_in && ack_q;
  // Only the defined command values go out
  assign bad_value = !wb_dat_in[CMD_READ_BIT] &&
    ((wb_dat_in[7:0] == SPECIAL_ADDR && wdata_q != QUICK_START_CODE) ||
     (wb_dat_in[7:0] == RESET_ADDR && wdata_q != FULL_RESET_CODE));
  assign go = wr && wb_adr_in == HCMD_OFS && wb_sel_in[0] && wb_sel_in[1] && !busy_q && !bad_value;
  assign qt = div_q == QW'(QUARTER_CYC - 1);

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      ack_q <= 1'b0;
      wb_dat_out <= '0;
    end else if (ce_in) begin
      ack_q <= wb_cyc_in && wb_stb_in && !ack_q;
      case (wb_adr_in)
        HWDATA_OFS: wb_dat_out <= {16'h0000, wdata_q};
        HRDATA_OFS: wb_dat_out <= {16'h0000, rdata_q};
        HSTATUS_OFS: wb_dat_out <= {29'h0, done_q, nack_q, busy_q};
        HPINS_OFS: wb_dat_out <= {29'h0, pins_q};
        default: wb_dat_out <= '0;
      endcase
    end
  end
  assign wb_ack_out = ack_q;

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      wdata_q <= '0;
      pins_q <= '0;
    end else if (ce_in && wr) begin
      if (wb_adr_in == HWDATA_OFS && wb_sel_in[0]) begin
        wdata_q[7:0] <= wb_dat_in[7:0];
      end
      if (wb_adr_in == HWDATA_OFS && wb_sel_in[1]) begin
        wdata_q[15:8] <= wb_dat_in[15:8];
      end
      if (wb_adr_in == HPINS_OFS && wb_sel_in[0]) begin
        pins_q <= wb_dat_in[2:0];
      end
    end
  end

  // Pin driver: generated 32kHz clock or trigger level
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      gen_div_q <= '0;
      gen_clk_q <= 1'b0;
      trig_out_q <= 1'b0;
    end else if (ce_in) begin
      gen_div_q <= gen_div_q == HW'(HALF_CYC - 1) ? '0 : gen_div_q + 1'b1;
      if (gen_div_q == HW'(HALF_CYC - 1)) begin
        gen_clk_q <= !gen_clk_q;
      end
      trig_out_q <= pins_q[PINS_CLKGEN_BIT] ? gen_clk_q : pins_q[PINS_TRIGGER_BIT];
    end
  end
  assign link.clock_source_select = pins_q[PINS_SELECT_BIT];
  assign link.clock_or_trigger_input = trig_out_q;

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      busy_q <= 1'b0;
      nack_q <= 1'b0;
      done_q <= 1'b0;
      rd_q <= 1'b0;
      ptr_q <= '0;
      rdata_q <= '0;
      step_q <= '0;
      ph_q <= '0;
      bit_q <= '0;
      div_q <= '0;
      shift_q <= '0;
      scl_q <= 1'b1;
      oe_q <= 1'b0;
    end else if (ce_in) begin
      if (go) begin
        busy_q <= 1'b1;
        nack_q <= 1'b0;
        done_q <= 1'b0;
        rd_q <= wb_dat_in[CMD_READ_BIT];
        ptr_q <= wb_dat_in[7:0];
        step_q <= '0;
        ph_q <= '0;
        bit_q <= '0;
        div_q <= '0;
      end else if (busy_q) begin
        div_q <= qt ? '0 : div_q + 1'b1;
        if (qt) begin
          ph_q <= ph_q + 1'b1;
          case (ph_q)
            2'd0: oe_q <= tok == TK_STOP || (tok == TK_WRITE && bit_q < 4'd8 && !shift_q[7]) ||
              (tok == TK_READ && bit_q == 4'd8 && step_q == 3'd5);
            2'd1: scl_q <= 1'b1;
            2'd2: begin
              if (tok == TK_START || tok == TK_STOP) begin
                oe_q <= tok == TK_START;
              end else if (bit_q < 4'd8) begin
                shift_q <= {shift_q[6:0], link.sda};
              end else if (tok == TK_WRITE && link.sda) begin
                nack_q <= 1'b1;
              end
            end
            default: begin
              if (tok == TK_STOP) begin
                busy_q <= 1'b0;
                done_q <= 1'b1;
              end else begin
                scl_q <= 1'b0;
                if (tok == TK_START || bit_q == 4'd8) begin
                  bit_q <= '0;
                  step_q <= nack_q ? stop_step : step_q + 1'b1;
                  shift_q <= byte_of(step_q + 1'b1, rd_q, ptr_q, wdata_q);
                  if (tok == TK_READ) begin
                    rdata_q <= {rdata_q[7:0], shift_q};
                  end
                end else begin
                  bit_q <= bit_q + 1'b1;
                end
              end
            end
          endcase
        end
      end
    end
  end

  assign link.scl = scl_q;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = oe_q;
endmodule

// file: tb/gauge_host_register_bank_monitor.sv
// Checker for the gauge link and device sideband
`timescale 1ns/1ps
module gauge_host_register_bank_monitor import gauge_pkg::*; (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic scl,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic clock_source_select,
  input wire logic clock_or_trigger_input,
  input wire logic quick_start_out,
  input wire logic full_reset_out,
  input wire logic conversion_done_out,
  input wire logic [15:0] compensation_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  sequence s_trig;
    !clock_source_select && $rose(clock_or_trigger_input);
  endsequence
  sequence s_rel;
    $fell(srst_in);
  endsequence
  property p_idle;
    s_rel |-> scl && !host_sda_oe && !dev_sda_oe;
  endproperty
  a_idle: assert property (p_idle) else $error("link not idle");
  property p_rst_comp;
    s_rel |-> compensation_out == COMP_RESET;
  endproperty
  a_rst_comp: assert property (p_rst_comp) else $error("comp default");
  property p_fr_comp;
    full_reset_out |-> ##[1:3] compensation_out == COMP_RESET;
  endproperty
  a_fr_comp: assert property (p_fr_comp) else $error("comp not restored");
  property p_fr_noack;
    full_reset_out |=> !full_reset_out && !dev_sda_oe;
  endproperty
  a_fr_noack: assert property (p_fr_noack) else $error("reset acked");
  property p_trig;
    s_trig |-> ##[3:5] quick_start_out;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger ignored");
  property p_qs;
    quick_start_out |=> !quick_start_out;
  endproperty
  a_qs: assert property (p_qs) else $error("quick start too long");
  property p_conv;
    conversion_done_out |=> !conversion_done_out [*8];
  endproperty
  a_conv: assert property (p_conv) else $error("conversion too soon");
  property p_sda;
    $changed(dev_sda_oe) |-> !scl;
  endproperty
  a_sda: assert property (p_sda) else $error("sda moved, scl high");
endmodule

// file: tb/gauge_host_register_bank_bench.sv
// Bench: host and device ends joined over the link
`timescale 1ns/1ps
module gauge_host_register_bank_bench import gauge_pkg::*;;
  localparam logic [15:0] REV = 16'h0011; // Arbitrary value
  logic clk, rst, cyc, stb, wwe, ack, done, qs, fr, nk, ce;
  logic [3:0] sel;
  logic [7:0] adr;
  logic [31:0] dat, rdat, q;
  logic [11:0] vs;
  logic signed [19:0] soc;
  logic [15:0] comp, r;
  logic [23:0] uv;
  int n_mismatch, tests_run, qn, dn, n, fn;
  gauge_link_if link();
  gauge_host #(.QUARTER_CYC(4)) u_gauge_host(.sys_clk_in(clk), .srst_in(rst), .ce_in(ce),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(wwe), .wb_adr_in(adr), .wb_dat_in(dat),
    .wb_sel_in(sel), .wb_dat_out(rdat), .wb_ack_out(ack), .link(link));
  gauge_device #(.VERSION_CODE(REV), .FIRST_TICKS(4), .LATER_TICKS(8), .TICK_CYC(4)) u_gauge_device(
    .sys_clk_in(clk), .srst_in(rst), .ce_in(ce), .link(link), .voltage_sample_in(vs),
    .soc_estimate_in(soc), .conversion_done_out(done), .quick_start_out(qs), .full_reset_out(fr),
    .compensation_out(comp), .cell_voltage_uv_out(uv));
  gauge_host_register_bank_monitor u_monitor(.sys_clk_in(clk), .srst_in(rst), .scl(link.scl),
    .host_sda_oe(link.host_sda_oe), .dev_sda_oe(link.dev_sda_oe),
    .clock_source_select(link.clock_source_select), .clock_or_trigger_input(link.clock_or_trigger_input),
    .quick_start_out(qs), .full_reset_out(fr), .conversion_done_out(done), .compensation_out(comp));
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (qs === 1'b1) qn++;
    if (done === 1'b1) dn++;
    if (fr === 1'b1) fn++;
  end
  task automatic close_out();
    if (n_mismatch == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int i = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    wwe <= we;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 50);
    if (i >= 50) begin
      n_mismatch++;
      close_out();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  // One two-wire transfer; r gets the word read, nk the nack flag
  task automatic op(input logic [7:0] p, input logic rd, input logic [15:0] w);
    int i = 0;
    wb(1'b1, HWDATA_OFS, {16'h0, w});
    wb(1'b1, HCMD_OFS, {23'h0, rd, p});
    do begin
      wb(1'b0, HSTATUS_OFS, 32'h0);
      i++;
    end while (q[2] !== 1'b1 && i < 1000);
    if (i >= 1000) begin
      n_mismatch++;
      close_out();
    end
    nk = q[1];
    wb(1'b0, HRDATA_OFS, 32'h0);
    r = q[15:0];
  endtask
  task automatic t_defaults();
    op(COMP_ADDR, 1'b1, 16'h0);
    chk("comp", 32'(r), 32'h9700);
    op(REV_ADDR, 1'b1, 16'h0);
    chk("rev", 32'(r), 32'(REV));
    op(8'h0a, 1'b1, 16'h0);
    chk("reserved", 32'(r), 32'hffff);
    op(SPECIAL_ADDR, 1'b1, 16'h0);
    chk("wo_read", 32'(r), 32'hffff);
    wb(1'b0, 8'h14, 32'h0);
    chk("unmapped", q, 32'h0);
    sel <= 4'h1;
    wb(1'b1, HCMD_OFS, 32'h10c);
    sel <= 4'hf;
    wb(1'b0, HSTATUS_OFS, 32'h0);
    chk("half_lane_cmd", q, 32'h4);
  endtask
  task automatic t_writes();
    op(COMP_ADDR, 1'b0, 16'h1234);
    chk("comp_out", 32'(comp), 32'h1234);
    op(8'h0d, 1'b0, 16'habcd);
    op(COMP_ADDR, 1'b1, 16'h0);
    chk("partial", 32'(r), 32'h1234);
    op(REV_ADDR, 1'b0, 16'h5555);
    op(REV_ADDR, 1'b1, 16'h0);
    chk("rev_ro", 32'(r), 32'(REV));
  endtask
  task automatic t_measure();
    int i = 0;
    op(VOLT_ADDR, 1'b0, 16'h0111);
    op(VOLT_ADDR, 1'b1, 16'h0);
    chk("volt", 32'(r), 32'h5a3);
    chk("uv", 32'(uv), 32'h5a3 * VOLT_STEP_UV_1S);
    op(CHG_ADDR, 1'b1, 16'h0);
    chk("chg_max", 32'(r), 32'hffff);
    soc <= -20'sd5;
    op(CHG_ADDR, 1'b1, 16'h0);
    chk("chg_min", 32'(r), 32'h0);
    soc <= 20'sh03a80;
    op(CHG_ADDR, 1'b1, 16'h0);
    chk("chg", 32'(r), 32'h3a80);
    @(negedge clk);
    n = dn;
    repeat (320) @(negedge clk);
    chk("conv_rate", dn - n, 10);
    // Drop the enable just after a pulse so it freezes low
    do begin
      @(posedge clk);
      i++;
    end while (done !== 1'b1 && i < 64);
    if (i >= 64) begin
      n_mismatch++;
      close_out();
    end
    ce <= 1'b0;
    @(posedge clk);
    n = dn;
    repeat (100) @(posedge clk);
    chk("ce_freeze", dn - n, 0);
    ce <= 1'b1;
  endtask
  task automatic t_quick();
    int d;
    n = qn;
    op(SPECIAL_ADDR, 1'b0, QUICK_START_CODE);
    chk("qs_cmd", qn - n, 1);
    wb(1'b1, HPINS_OFS, 32'h2);
    repeat (8) @(posedge clk);
    chk("qs_pin", qn - n, 2);
    wb(1'b1, HPINS_OFS, 32'h1);
    wb(1'b1, HPINS_OFS, 32'h7);
    d = dn;
    repeat (2000) @(posedge clk);
    chk("ext_no_qs", qn - n, 2);
    chk("ext_rate", 32'(dn - d < 3), 32'h1);
    wb(1'b1, HPINS_OFS, 32'h0);
  endtask
  task automatic t_full();
    op(COMP_ADDR, 1'b0, 16'h4321);
    n = fn;
    op(RESET_ADDR, 1'b0, FULL_RESET_CODE);
    chk("no_ack", 32'(nk), 32'h1);
    chk("fr_pulse", fn - n, 1);
    chk("comp_def", 32'(comp), 32'h9700);
  endtask
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {cyc, stb, wwe, adr, dat} = '0;
    ce = 1'b1;
    sel = 4'hf;
    vs = 12'h5a3;
    soc = 20'sh12345;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_defaults();
    t_writes();
    t_measure();
    t_quick();
    t_full();
    close_out();
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    close_out();
  end
endmodule
